// ### hw/ffa_pkg.sv
// Constants, commands and state types for the frame flash host controller.
// Assumes a 250 MHz system clock; all pin timing is counted in its cycles.
package ffa_pkg;
  // ==========================================
  // Clock and pin timing
  localparam int CLK_NS = 4;
  localparam int T_SU_NS = 50;
  localparam int T_WP_NS = 60;
  localparam int T_WH_NS = 60;
  localparam int T_WB_NS = 200;
  localparam int T_CR_NS = 250;
  localparam int T_RP_NS = 60;
  localparam int T_REH_NS = 60;
  localparam int T_CEA_NS = 60;
  localparam int T_BUSY_MAX_NS = 1000000;
  localparam int CNT_SU = (T_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_WH = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_WB = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_CR = (T_CR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_REH = (T_REH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_CEA = T_CEA_NS / CLK_NS + 1;
  localparam int CNT_BUSY_MAX = T_BUSY_MAX_NS / CLK_NS;
  localparam int CNT_W = 18;

  // ==========================================
  // Commands and status bits
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_CONF = 8'h10;
  localparam logic [7:0] CMD_STAT = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_WPN_BIT = 7;

  // ==========================================
  // Geometry
  localparam int ADDR_W = 19;
  localparam int BLK_MSB = 18;
  localparam int BLK_LSB = 12;
  localparam int BLK_W = BLK_MSB - BLK_LSB + 1;
  localparam int NUM_BLOCKS = 128;
  localparam int FRAME_BYTES = 32;
  localparam int LEN_W = 6;
  localparam int FIFO_DEPTH = 8;

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_STAT = 2'b01,
    OP_PROG = 2'b10,
    OP_RESET = 2'b11
  } ffa_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WSU = 4'b0001,
    ST_WLO = 4'b0010,
    ST_WHI = 4'b0011,
    ST_WDAT = 4'b0100,
    ST_WAITB = 4'b0101,
    ST_WAITR = 4'b0110,
    ST_CEW = 4'b0111,
    ST_RLO = 4'b1000,
    ST_RHI = 4'b1001,
    ST_PARK = 4'b1010,
    ST_DONE = 4'b1011
  } ffa_state_t;

  typedef enum logic [2:0] {
    SP_CMD = 3'b000,
    SP_A0 = 3'b001,
    SP_A1 = 3'b010,
    SP_A2 = 3'b011,
    SP_DATA = 3'b100,
    SP_CONF = 3'b101,
    SP_STAT = 3'b110
  } ffa_step_t;
endpackage : ffa_pkg

// ### hw/ffa_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module ffa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic do_wr, do_rd;

  // ==========================================
  // Pointer and count update
  always_comb begin
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_wr) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (PW + 1)'(do_wr) - (PW + 1)'(do_rd);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = (count != FULL_CNT);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
endmodule : ffa_fifo

// ### hw/ffa_host.sv
// Host controller driving a frame-organised NAND flash over its byte port.
// Assumes pins are asynchronous to clk_i; ready/busy has an external pull-up.
`timescale 1ns/10ps
// Operation
// - Host waits at least 250 ns from select low to read strobe low.
// - Host keeps a defective block table and refuses programs to them.
// - Host never erases a block just to clear its defect marker.
// - Host reads status after program and retires block on failure; the host never retires block 0.
// - Host records blocks whose erase failed and keeps accesses away; the host issues no erase and refuses only programs to recorded blocks.
// - Select may go inactive between sequential bytes; device keeps state.
// - After select returns, host waits over 60 ns before sampling.
// - Frame read is command 00h then three address bytes.
// - Program is 80h, address, data, then 10h; no data starts nothing.
module ffa_host
  import ffa_pkg::*;
#(
  parameter int BUSY_LIMIT = CNT_BUSY_MAX
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire ffa_op_t cmd_op_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [LEN_W-1:0] cmd_len_i,
  input wire logic wdata_valid_i,
  output logic wdata_ready_o,
  input wire logic [7:0] wdata_i,
  output logic rdata_valid_o,
  input wire logic rdata_ready_i,
  output logic [7:0] rdata_o,
  input wire logic mark_valid_i,
  input wire logic [BLK_W-1:0] mark_blk_i,
  output logic done_o,
  output logic fail_o,
  output logic refused_o,
  output logic timeout_o,
  output logic [7:0] status_o,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic output_strobe_n_o,
  output logic wp_n_o,
  input wire logic ready_busy_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_n_o
);
  ffa_state_t state, next_state;
  ffa_step_t step, next_step;
  ffa_op_t op, next_op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [LEN_W-1:0] left, next_left;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [NUM_BLOCKS-1:0] bad, next_bad;
  logic [7:0] next_io, next_stat;
  logic is_stat, next_is_stat;
  logic next_done, next_fail, next_refused, next_timeout;
  logic next_ce_n, next_cle, next_ale, next_we_n, next_re_n, next_oe_n;
  logic rb_m, ready_s;
  logic [7:0] io_m, io_s;
  logic push, fifo_in_ready;
  logic [BLK_W-1:0] blk, cmd_blk;

  assign blk = addr[BLK_MSB:BLK_LSB];
  assign cmd_blk = cmd_addr_i[BLK_MSB:BLK_LSB];
  assign cmd_ready_o = (state == ST_IDLE);
  assign wdata_ready_o = (state == ST_WDAT);
  assign wp_n_o = 1'b1;

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rb_m <= 1'b0;
      ready_s <= 1'b0;
      io_m <= '0;
      io_s <= '0;
    end else begin
      rb_m <= ready_busy_n_i;
      ready_s <= rb_m;
      io_m <= io_i;
      io_s <= io_m;
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_step = step;
    next_op = op;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_left = left;
    next_addr = addr;
    next_bad = bad;
    next_io = io_o;
    next_stat = status_o;
    next_is_stat = is_stat;
    next_done = 1'b0;
    next_fail = fail_o;
    next_refused = 1'b0;
    next_timeout = timeout_o;
    push = 1'b0;
    if (mark_valid_i && mark_blk_i != '0) begin
      next_bad[mark_blk_i] = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (cmd_valid_i) begin
          if ((cmd_op_i == OP_PROG && bad[cmd_blk] && cmd_blk != '0) ||
              ((cmd_op_i == OP_READ || cmd_op_i == OP_PROG) &&
               (cmd_len_i == '0 || cmd_len_i > LEN_W'(FRAME_BYTES)))) begin
            next_refused = 1'b1;
          end else begin
            next_op = cmd_op_i;
            next_addr = cmd_addr_i;
            next_step = SP_CMD;
            next_fail = 1'b0;
            next_timeout = 1'b0;
            next_is_stat = (cmd_op_i == OP_STAT);
            next_left = (cmd_op_i == OP_STAT) ? LEN_W'(1) : cmd_len_i;
            case (cmd_op_i)
              OP_READ: next_io = CMD_READ;
              OP_STAT: next_io = CMD_STAT;
              OP_PROG: next_io = CMD_PROG;
              default: next_io = CMD_RESET;
            endcase
            next_state = ST_WSU;
            next_cnt = CNT_W'(CNT_SU - 1);
          end
        end
      end
      ST_WSU: begin
        if (cnt == '0) begin
          next_state = ST_WLO;
          next_cnt = CNT_W'(CNT_WP - 1);
        end
      end
      ST_WLO: begin
        if (cnt == '0) begin
          next_state = ST_WHI;
          next_cnt = CNT_W'(CNT_WH - 1);
        end
      end
      ST_WHI: begin
        if (cnt == '0) begin
          next_state = ST_WSU;
          next_cnt = CNT_W'(CNT_SU - 1);
          case (step)
            SP_CMD: begin
              if (op == OP_RESET || op == OP_STAT) begin
                next_state = (op == OP_RESET) ? ST_WAITB : ST_CEW;
                next_cnt = (op == OP_RESET) ? CNT_W'(CNT_WB - 1) : CNT_W'(CNT_CR - 1);
              end else begin
                next_step = SP_A0;
                next_io = addr[7:0];
              end
            end
            SP_A0: begin
              next_step = SP_A1;
              next_io = addr[15:8];
            end
            SP_A1: begin
              next_step = SP_A2;
              next_io = {5'h00, addr[ADDR_W-1:16]};
            end
            SP_A2: begin
              if (op == OP_READ) begin
                next_state = ST_WAITB;
                next_cnt = CNT_W'(CNT_WB - 1);
              end else begin
                next_step = SP_DATA;
                next_state = ST_WDAT;
              end
            end
            SP_DATA: begin
              next_left = left - 1'b1;
              if (left == LEN_W'(1)) begin
                next_step = SP_CONF;
                next_io = CMD_CONF;
              end else begin
                next_state = ST_WDAT;
              end
            end
            SP_CONF: begin
              next_state = ST_WAITB;
              next_cnt = CNT_W'(CNT_WB - 1);
            end
            default: begin
              next_state = ST_CEW;
              next_cnt = CNT_W'(CNT_CR - 1);
            end
          endcase
        end
      end
      ST_WDAT: begin
        if (wdata_valid_i) begin
          next_io = wdata_i;
          next_state = ST_WSU;
          next_cnt = CNT_W'(CNT_SU - 1);
        end
      end
      ST_WAITB: begin
        if (cnt == '0) begin
          next_state = ST_WAITR;
          next_cnt = CNT_W'(BUSY_LIMIT - 1);
        end
      end
      ST_WAITR: begin
        if (ready_s) begin
          if (op == OP_READ) begin
            next_state = ST_CEW;
            next_cnt = CNT_W'(CNT_CR - 1);
          end else if (op == OP_PROG) begin
            next_step = SP_STAT;
            next_io = CMD_STAT;
            next_is_stat = 1'b1;
            next_left = LEN_W'(1);
            next_state = ST_WSU;
            next_cnt = CNT_W'(CNT_SU - 1);
          end else begin
            next_state = ST_DONE;
          end
        end else if (cnt == '0) begin
          next_timeout = 1'b1;
          next_state = ST_DONE;
        end
      end
      ST_CEW: begin
        if (cnt == '0) begin
          next_state = ST_RLO;
          next_cnt = CNT_W'(CNT_RP - 1);
        end
      end
      ST_RLO: begin
        if (cnt == '0) begin
          if (is_stat) begin
            next_stat = io_s;
            if (op == OP_PROG && io_s[ST_FAIL_BIT]) begin
              next_fail = 1'b1;
              if (blk != '0) begin
                next_bad[blk] = 1'b1;
              end
            end
          end else begin
            push = 1'b1;
          end
          next_state = ST_RHI;
          next_cnt = CNT_W'(CNT_REH - 1);
        end
      end
      ST_RHI: begin
        if (cnt == '0) begin
          next_left = left - 1'b1;
          if (left == LEN_W'(1)) begin
            next_state = ST_DONE;
          end else if (!fifo_in_ready) begin
            next_state = ST_PARK;
          end else begin
            next_state = ST_RLO;
            next_cnt = CNT_W'(CNT_RP - 1);
          end
        end
      end
      ST_PARK: begin
        if (fifo_in_ready) begin
          next_state = ST_CEW;
          next_cnt = CNT_W'(CNT_CR - 1);
        end
      end
      ST_DONE: begin
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // ==========================================
  // Pin levels for the next state
  always_comb begin
    next_ce_n = (next_state == ST_IDLE || next_state == ST_PARK || next_state == ST_DONE);
    next_cle = (next_state == ST_WSU || next_state == ST_WLO || next_state == ST_WHI) &&
               (next_step == SP_CMD || next_step == SP_CONF || next_step == SP_STAT);
    next_ale = (next_state == ST_WSU || next_state == ST_WLO || next_state == ST_WHI) &&
               (next_step == SP_A0 || next_step == SP_A1 || next_step == SP_A2);
    next_we_n = (next_state != ST_WLO);
    next_re_n = (next_state != ST_RLO);
    next_oe_n = !(next_state == ST_WSU || next_state == ST_WLO || next_state == ST_WHI);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      step <= SP_CMD;
      op <= OP_READ;
      cnt <= '0;
      left <= '0;
      addr <= '0;
      bad <= '0;
      io_o <= '0;
      status_o <= '0;
      is_stat <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      refused_o <= 1'b0;
      timeout_o <= 1'b0;
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      output_strobe_n_o <= 1'b1;
      io_oe_n_o <= 1'b1;
    end else begin
      state <= next_state;
      step <= next_step;
      op <= next_op;
      cnt <= next_cnt;
      left <= next_left;
      addr <= next_addr;
      bad <= next_bad;
      io_o <= next_io;
      status_o <= next_stat;
      is_stat <= next_is_stat;
      done_o <= next_done;
      fail_o <= next_fail;
      refused_o <= next_refused;
      timeout_o <= next_timeout;
      ce_n_o <= next_ce_n;
      cle_o <= next_cle;
      ale_o <= next_ale;
      we_n_o <= next_we_n;
      output_strobe_n_o <= next_re_n;
      io_oe_n_o <= next_oe_n;
    end
  end

  // ==========================================
  // Read data buffer
  ffa_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(io_s),
    .out_valid_o(rdata_valid_o),
    .out_ready_i(rdata_ready_i),
    .out_data_o(rdata_o)
  );

  // ==========================================
  // Assertions
  logic [8:0] ce_low_cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ce_low_cnt <= '0;
    end else if (ce_n_o) begin
      ce_low_cnt <= '0;
    end else if (ce_low_cnt != 9'h1FF) begin
      ce_low_cnt <= ce_low_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prog_ready;
    state == ST_WAITR && ready_s && op == OP_PROG;
  endsequence
  sequence s_status_cmd;
    state == ST_WSU && step == SP_STAT && io_o == CMD_STAT && cle_o;
  endsequence

  property p_ready_first;
    $fell(output_strobe_n_o) && !is_stat |-> ready_s;
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("strobe while busy");
  property p_ce_to_re;
    $fell(output_strobe_n_o) |-> ce_low_cnt >= 9'(CNT_CR);
  endproperty
  a_ce_to_re: assert property (p_ce_to_re) else $error("select to strobe too short");
  property p_sample_late;
    state == ST_RLO && cnt == '0 |-> ce_low_cnt > 9'(CNT_CEA - 1);
  endproperty
  a_sample_late: assert property (p_sample_late) else $error("sample too soon after select");
  property p_park;
    state == ST_RHI && cnt == '0 && left != LEN_W'(1) && !fifo_in_ready |=> ce_n_o && state == ST_PARK;
  endproperty
  a_park: assert property (p_park) else $error("select not released on stall");
  property p_read_cmd;
    state == ST_WLO && step == SP_CMD && op == OP_READ |-> io_o == CMD_READ && cle_o && !io_oe_n_o;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("wrong read command");
  property p_reset_cmd;
    state == ST_WHI && step == SP_CMD && op == OP_RESET && cnt == '0 |-> io_o == CMD_RESET ##1 state == ST_WAITB;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset sequence wrong");
  property p_empty_prog;
    state == ST_IDLE && cmd_valid_i && cmd_op_i == OP_PROG && cmd_len_i == '0 |=> refused_o && state == ST_IDLE;
  endproperty
  a_empty_prog: assert property (p_empty_prog) else $error("empty program accepted");
  property p_bad_refuse;
    state == ST_IDLE && cmd_valid_i && cmd_op_i == OP_PROG && bad[cmd_blk] && cmd_blk != '0 |=> refused_o;
  endproperty
  a_bad_refuse: assert property (p_bad_refuse) else $error("program to bad block");
  property p_prog_status;
    s_prog_ready |=> s_status_cmd;
  endproperty
  a_prog_status: assert property (p_prog_status) else $error("no status after program");
  property p_mark;
    mark_valid_i && mark_blk_i != '0 |=> bad[$past(mark_blk_i)];
  endproperty
  a_mark: assert property (p_mark) else $error("failed block not recorded");
  property p_blk0;
    !bad[0];
  endproperty
  a_blk0: assert property (p_blk0) else $error("block zero marked bad");
endmodule : ffa_host

// ### tb/ffa_flash_model.sv
// Behavioural frame flash device driven by the host pins.
// Assumes a pull-up on ready/busy; the device has no clock.
`timescale 1ns/10ps
module ffa_flash_model #(
  parameter int BAD_BLK = 3
) (
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic [7:0] io_i,
  input wire logic fail_i,
  input wire logic stuck_i,
  output logic [7:0] io_o,
  output logic rb_n_o = 1'b1
);
  logic [7:0] mem [int];
  logic [7:0] pbuf [int];
  logic [7:0] dq = 8'hFF;
  logic drv = 1'b0, fl = 1'b0, st = 1'b0, prg = 1'b0;
  int ac = 0, adr = 0, bt = 0;
  event go;
  // Released bus shows the inverse of the last byte
  assign io_o = drv ? dq : ~dq;
  // ==========
  // Array
  // erased value
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  initial mem[BAD_BLK * 4096] = 8'h00;
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      st = io_i == 8'h70;
      ac = 0;
      if (io_i == 8'h00 || io_i == 8'h80) begin
        prg = io_i[7];
        pbuf.delete();
      end
      if (io_i == 8'h10 && prg && pbuf.size() > 0) begin
        foreach (pbuf[k]) mem[k] = rd(k) & pbuf[k];
        fl = fail_i;
        prg = 1'b0;
        bt = 60;
        ->go;
      end
      if (io_i == 8'hFF) begin
        bt = 20;
        ->go;
      end
    end else if (!ce_n_i && ale_i) begin
      adr[8*ac+:8] = io_i;
      ac++;
      if (ac == 3) begin
        adr = adr & 32'h7FFFF;
        bt = 40;
        if (!prg) ->go;
      end
    end else if (!ce_n_i && prg) begin
      pbuf[adr] = io_i;
      adr++;
    end
  end
  // ==========
  // Busy and output
  // busy, dropped when select rises during a read
  always @(go) begin
    #20ns;
    if (!(ce_n_i && bt == 40)) begin
      rb_n_o = 1'b0;
      for (int i = 0; (i < bt || stuck_i) && !(ce_n_i && bt == 40); i++) #4ns;
      rb_n_o = 1'b1;
    end
  end
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      #20ns;
      dq = st ? {1'b1, rb_n_o, 5'h00, fl} : rd(adr);
      drv = 1'b1;
      if (!st) adr++;
    end
  end
  always @(posedge re_n_i) begin
    #10ns;
    drv = 1'b0;
  end
endmodule : ffa_flash_model

// ### tb/test_frame_flash_access_timing.sv
// Self-checking bench for the frame flash host controller.
// Assumes the flash model on the pins.
`timescale 1ns/10ps
module test_frame_flash_access_timing
  import ffa_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0, wdata_valid_i = 1'b0, rdata_ready_i = 1'b0, mark_valid_i = 1'b0;
  ffa_op_t cmd_op_i = OP_READ;
  logic [ADDR_W-1:0] cmd_addr_i = '0;
  logic [LEN_W-1:0] cmd_len_i = '0;
  logic [BLK_W-1:0] mark_blk_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic cmd_ready_o, wdata_ready_o, rdata_valid_o, done_o, fail_o, refused_o, timeout_o;
  logic ce_n_o, cle_o, ale_o, we_n_o, output_strobe_n_o, wp_n_o, io_oe_n_o, rb_n;
  logic [7:0] rdata_o, status_o, io_o, f_io, bus;
  logic fail_in = 1'b0, stuck = 1'b0, stall = 1'b0, rf = 1'b0;
  logic [7:0] ref_mem [int];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  int err_total = 0, check_count = 0, cyc = 0;
  real t_ce = 0.0;
  assign bus = io_oe_n_o ? f_io : io_o;

  ffa_host #(.BUSY_LIMIT(200)) dut (.clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_op_i, .cmd_addr_i,
    .cmd_len_i, .wdata_valid_i, .wdata_ready_o, .wdata_i, .rdata_valid_o, .rdata_ready_i, .rdata_o,
    .mark_valid_i, .mark_blk_i, .done_o, .fail_o, .refused_o, .timeout_o, .status_o, .ce_n_o, .cle_o,
    .ale_o, .we_n_o, .output_strobe_n_o, .wp_n_o, .ready_busy_n_i(rb_n), .io_i(bus), .io_o, .io_oe_n_o);
  ffa_flash_model #(.BAD_BLK(3)) flash (.ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o),
    .re_n_i(output_strobe_n_o), .io_i(bus), .fail_i(fail_in), .stuck_i(stuck), .io_o(f_io), .rb_n_o(rb_n));

  // ==========
  // Helpers
  task automatic conclude;
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [7:0] exp_byte(input int a);
    if (ref_mem.exists(a)) return ref_mem[a];
    return (a == 3 * 4096) ? 8'h00 : 8'hFF;
  endfunction : exp_byte

  task automatic run(input ffa_op_t op, input int a, input int n);
    @(negedge clk_i);
    cmd_op_i = op;
    cmd_addr_i = a[ADDR_W-1:0];
    cmd_len_i = n[LEN_W-1:0];
    cmd_valid_i = 1'b1;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    rf = refused_o === 1'b1;
    for (int k = 0; k < 20000 && done_o !== 1'b1 && timeout_o !== 1'b1 && !rf; k++) begin
      @(posedge clk_i);
      #1;
      rf = refused_o === 1'b1;
    end
    chk("op end", 8'h01, {7'h00, (done_o === 1'b1 || timeout_o === 1'b1 || rf)});
  endtask : run

  task automatic prog(input int a, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom());
      wq.push_back(d);
      ref_mem[a + i] = exp_byte(a + i) & d;
    end
    run(OP_PROG, a, n);
  endtask : prog

  task automatic rd_chk(input int a, input int n, input logic hold);
    rq.delete();
    stall = hold;
    fork
      run(OP_READ, a, n);
      begin
        repeat (900) @(negedge clk_i);
        if (hold) chk("held bytes", 8'h00, 8'(rq.size()));
        if (hold) chk("park select", 8'h01, {7'h00, ce_n_o});
        stall = 1'b0;
      end
    join
    repeat (40) @(posedge clk_i);
    chk("read count", n[7:0], 8'(rq.size()));
    foreach (rq[i]) chk("read byte", exp_byte(a + i), rq[i]);
  endtask : rd_chk

  // ==========
  // Drivers and pin checks
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (wdata_valid_i && wdata_ready_o) void'(wq.pop_front());
    if (rdata_valid_o && rdata_ready_i) rq.push_back(rdata_o);
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end
  always @(negedge clk_i) begin
    wdata_valid_i <= wq.size() > 0;
    wdata_i <= wq.size() > 0 ? wq[0] : 8'h00;
    rdata_ready_i <= !stall && $urandom_range(3) != 0;
  end
  always @(negedge ce_n_o) t_ce = $realtime;
  always @(negedge output_strobe_n_o) begin
    chk("select gap", 8'h01, {7'h00, ($realtime - t_ce >= 250.0)});
    chk("ready at strobe", 8'h01, {7'h00, rb_n});
  end

  // ==========
  // Scenarios
  initial begin
    int a, n, c;
    void'($urandom(96643));
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    run(OP_RESET, 0, 0);
    chk("reset done", 8'h00, {7'h00, rf});
    run(OP_STAT, 0, 0);
    chk("status", 8'hC0, status_o);
    chk("write enable", 8'h01, {7'h00, wp_n_o});
    for (int t = 0; t < 4; t++) begin
      c = t ? $urandom_range(31) : 0;
      n = t ? $urandom_range(32 - c, 1) : 32;
      a = (16 + 8 * t + $urandom_range(7)) * 4096 + $urandom_range(127) * 32 + c;
      prog(a, n);
      chk("prog fail", 8'h00, {7'h00, fail_o});
      rd_chk(a, n, t == 0);
    end
    rd_chk(3 * 4096, 2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run(i[1] ? OP_PROG : OP_READ, 4096, i[0] ? 33 : 0);
      chk("length refused", 8'h01, {7'h00, rf});
    end
    fail_in = 1'b1;
    prog(40 * 4096, 4);
    fail_in = 1'b0;
    chk("fail flag", 8'h01, {7'h00, fail_o});
    chk("fail status", 8'hC1, status_o);
    run(OP_PROG, 40 * 4096 + 64, 1);
    chk("retired block", 8'h01, {7'h00, rf});
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_i);
      mark_blk_i = i ? 7'h09 : 7'h00;
      mark_valid_i = 1'b1;
      @(negedge clk_i);
      mark_valid_i = 1'b0;
    end
    prog(160, 2);
    chk("block zero", 8'h00, {7'h00, rf});
    rd_chk(160, 2, 1'b0);
    run(OP_PROG, 9 * 4096, 1);
    chk("marked block", 8'h01, {7'h00, rf});
    stuck = 1'b1;
    run(OP_READ, 4096, 1);
    chk("busy limit", 8'h01, {7'h00, timeout_o});
    stuck = 1'b0;
    run(OP_RESET, 0, 0);
    chk("recovered", 8'h00, {7'h00, timeout_o});
    conclude();
  end
endmodule : test_frame_flash_access_timing
